// ### hsfs_seq.sv
// hot-swap fault sequencer with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1: insertion delay before switch turn-on
// RL2: discharge needs pin in band full time
// RL3: discharge starts after further fixed delay
// RL4: discharge enables output pull-down path
// RL5: pin pull-down while input invalid
// RL6: input validity with lockout hysteresis
// RL7: enable level with on hysteresis
// RL8: output above 80 percent postpones start
// RL9: below 70 percent clears short, resumes
// RL10: gate-drain short postpones, clears below ok
// RL11: low gate drive flags and faults
// RL12: gate fault timeout latches fault
// RL13: soft-start timeout latches fault
// RL14: overcurrent warning pulled low above level
// RL15: clamp selected by output voltage region
// RL16: soft-start held low during insertion
// RL17: switch off until enable, then ramp
// RL18: synced flags, timers cleared while invalid
// RL19: latched fault until enable cycled
module hsfs_seq #(
  parameter int unsigned INS_CYC = hsfs_pkg::INSERT_DELAY_CYC,
  parameter int unsigned QUAL_CYC = hsfs_pkg::DISCH_QUAL_CYC,
  parameter int unsigned DLY_CYC = hsfs_pkg::DISCH_START_CYC,
  parameter int unsigned GF_CYC = hsfs_pkg::GATE_FAULT_CYC,
  parameter int unsigned SS_CYC = hsfs_pkg::SS_MAX_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // analog comparator flags, asynchronous
  input wire hsfs_pkg::hsfs_cmp_t cmp_async,
  // power stage controls
  output logic gate_enable,
  output logic ss_hold,
  output logic out_discharge,
  output logic pin_pulldown,
  output hsfs_pkg::hsfs_clamp_t current_limit_reference,
  // status pins
  output logic power_good_out,
  output logic overcurrent_warning_out,
  output logic overcurrent_warning_oe_n,
  output logic irq
);

  hsfs_pkg::hsfs_cmp_t cmp_s1_r, cmp;
  logic valid_r, valid_nxt, en_on_r, en_on_nxt, en_go;
  hsfs_pkg::hsfs_state_t state_r, state_nxt;
  logic [hsfs_pkg::CNT_W-1:0] ins_cnt_r, ins_cnt_nxt, ss_cnt_r, ss_cnt_nxt, gf_cnt_r, gf_cnt_nxt;
  logic [hsfs_pkg::CNT_W-1:0] qual_cnt_r, qual_cnt_nxt, dly_cnt_r, dly_cnt_nxt;
  logic pd_cmd_r, pd_cmd_nxt, discharge_r, discharge_nxt;
  logic ds_short_r, ds_short_nxt, dg_short_r, dg_short_nxt;
  logic gate_low_r, gate_low_nxt, ss_fault_r, ss_fault_nxt, gf_fault_r, gf_fault_nxt;
  logic ins_done, ss_to, gf_to, up_ok, in_band, counting;
  hsfs_pkg::hsfs_clamp_t clamp_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [hsfs_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, events, w1c;
  logic acc, wr_pend_r, wr_pend_nxt;
  logic [3:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] rd_mux;
  hsfs_pkg::hsfs_status_t status_w;

  // two-flop synchroniser for all comparator flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1_r <= '0;
      cmp <= '0;
    end else begin
      cmp_s1_r <= cmp_async;
      cmp <= cmp_s1_r; // RL18
    end
  end

  // supply validity and enable level, each with hysteresis
  assign valid_nxt = valid_r ? cmp.uvlo_hold : cmp.uvlo_rise; // RL6
  assign en_on_nxt = valid_r & (en_on_r ? cmp.pin_hold : cmp.pin_on); // RL7
  assign en_go = en_on_r & ctrl_r[hsfs_pkg::CTRL_RUN_BIT];

  // discharge command qualification and start delay
  assign in_band = cmp.pin_above_lo & ~cmp.pin_above_hi;
  assign qual_cnt_nxt = (valid_r && in_band && !pd_cmd_r) ? qual_cnt_r + 32'd1 : '0; // RL2
  assign pd_cmd_nxt = valid_r && !en_on_r &&
                      (pd_cmd_r || (in_band && qual_cnt_r == QUAL_CYC - 1)); // RL2
  assign dly_cnt_nxt = (pd_cmd_r && !discharge_r) ? dly_cnt_r + 32'd1 : '0;
  assign discharge_nxt = pd_cmd_nxt &&
                         (discharge_r || (pd_cmd_r && dly_cnt_r == DLY_CYC - 1)); // RL3

  // sequencing timers
  assign ins_done = (state_r == hsfs_pkg::ST_INSERT) && (ins_cnt_r == INS_CYC - 1);
  assign ins_cnt_nxt = (state_r == hsfs_pkg::ST_INSERT && !ins_done) ? ins_cnt_r + 32'd1 : '0;
  assign counting = (state_r == hsfs_pkg::ST_INSERT) || (state_r == hsfs_pkg::ST_RAMP);
  assign ss_cnt_nxt = !counting ? (state_r == hsfs_pkg::ST_POSTPONE ? ss_cnt_r : '0)
                    : (ss_to ? ss_cnt_r : ss_cnt_r + 32'd1); // RL13
  assign gf_cnt_nxt = (counting && cmp.gate_drive_low && !gf_to) ? gf_cnt_r + 32'd1
                    : (state_r == hsfs_pkg::ST_POSTPONE && cmp.gate_drive_low ? gf_cnt_r : '0); // RL12
  assign ss_to = (state_r == hsfs_pkg::ST_RAMP) && (ss_cnt_r >= SS_CYC - 1); // RL13
  assign gf_to = (state_r == hsfs_pkg::ST_RAMP) && cmp.gate_drive_low &&
                 (gf_cnt_r >= GF_CYC - 1); // RL12
  assign up_ok = cmp.vout_above_90 & cmp.gate_near_pump; // RL13

  // start-up postponement flags, set wins over clear
  assign ds_short_nxt = ((ins_done || state_r == hsfs_pkg::ST_POSTPONE) && cmp.vout_above_80) ||
                        (ds_short_r && cmp.vout_above_70 && state_r != hsfs_pkg::ST_OFF); // RL8 RL9
  assign dg_short_nxt = (state_r == hsfs_pkg::ST_OFF && en_go && !discharge_r &&
                         cmp.gate_below_short) ||
                        (dg_short_r && !cmp.gate_below_ok && state_r != hsfs_pkg::ST_OFF); // RL10

  // fault flags persist until the sequencer returns to off
  assign gate_low_nxt = (gate_low_r && state_r != hsfs_pkg::ST_OFF) ||
                        (state_r == hsfs_pkg::ST_ON && cmp.gate_drive_low) ||
                        (ss_to && cmp.gate_drive_low); // RL11
  assign ss_fault_nxt = (ss_fault_r && state_r != hsfs_pkg::ST_OFF) || (ss_to && !up_ok);
  assign gf_fault_nxt = (gf_fault_r && state_r != hsfs_pkg::ST_OFF) || (gf_to && !up_ok);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      hsfs_pkg::ST_OFF: begin
        if (en_go && !discharge_r) state_nxt = hsfs_pkg::ST_INSERT; // RL17
      end
      hsfs_pkg::ST_INSERT: begin
        if (ins_done) begin // RL1
          state_nxt = (dg_short_r || cmp.vout_above_80) ? hsfs_pkg::ST_POSTPONE
                    : hsfs_pkg::ST_RAMP; // RL8 RL10
        end
      end
      hsfs_pkg::ST_POSTPONE: begin
        if (!dg_short_r && !ds_short_r) state_nxt = hsfs_pkg::ST_RAMP; // RL9 RL10
      end
      hsfs_pkg::ST_RAMP: begin
        if (up_ok) state_nxt = hsfs_pkg::ST_ON;
        else if (ss_to || gf_to) state_nxt = hsfs_pkg::ST_FAULT; // RL12 RL13
      end
      hsfs_pkg::ST_ON: begin
        if (cmp.gate_drive_low) state_nxt = hsfs_pkg::ST_FAULT; // RL11
      end
      hsfs_pkg::ST_FAULT: begin
        state_nxt = hsfs_pkg::ST_FAULT; // RL19
      end
      default: begin
        state_nxt = hsfs_pkg::ST_OFF;
      end
    endcase
    if (!valid_r || !en_go || discharge_r) state_nxt = hsfs_pkg::ST_OFF; // RL18 RL19
  end

  // current-limit clamp by output region
  assign clamp_nxt = !cmp.vout_above_abs ? hsfs_pkg::CLAMP_LOW
                   : !cmp.vout_above_40 ? hsfs_pkg::CLAMP_START
                   : !cmp.vout_above_80 ? hsfs_pkg::CLAMP_MID
                   : hsfs_pkg::CLAMP_FULL; // RL15

  // sequencer state and timers, all cleared while the input is invalid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_r <= 1'b0;
      en_on_r <= 1'b0;
      state_r <= hsfs_pkg::ST_OFF;
      {ins_cnt_r, ss_cnt_r, gf_cnt_r, qual_cnt_r, dly_cnt_r} <= '0;
      {pd_cmd_r, discharge_r, ds_short_r, dg_short_r} <= '0;
      {gate_low_r, ss_fault_r, gf_fault_r} <= '0;
    end else if (!valid_r) begin
      valid_r <= valid_nxt;
      en_on_r <= 1'b0;
      state_r <= hsfs_pkg::ST_OFF;
      {ins_cnt_r, ss_cnt_r, gf_cnt_r, qual_cnt_r, dly_cnt_r} <= '0; // RL18
      {pd_cmd_r, discharge_r, ds_short_r, dg_short_r} <= '0;
      {gate_low_r, ss_fault_r, gf_fault_r} <= '0;
    end else begin
      valid_r <= valid_nxt;
      en_on_r <= en_on_nxt;
      state_r <= state_nxt;
      {ins_cnt_r, ss_cnt_r, gf_cnt_r} <= {ins_cnt_nxt, ss_cnt_nxt, gf_cnt_nxt};
      {qual_cnt_r, dly_cnt_r} <= {qual_cnt_nxt, dly_cnt_nxt};
      {pd_cmd_r, discharge_r} <= {pd_cmd_nxt, discharge_nxt};
      {ds_short_r, dg_short_r} <= {ds_short_nxt, dg_short_nxt};
      {gate_low_r, ss_fault_r, gf_fault_r} <= {gate_low_nxt, ss_fault_nxt, gf_fault_nxt};
    end
  end

  // registered pin outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_enable <= 1'b0;
      ss_hold <= 1'b1;
      out_discharge <= 1'b0;
      pin_pulldown <= 1'b1;
      current_limit_reference <= hsfs_pkg::CLAMP_LOW;
      power_good_out <= 1'b0;
      overcurrent_warning_out <= 1'b1;
      overcurrent_warning_oe_n <= 1'b1;
    end else begin
      gate_enable <= (state_nxt == hsfs_pkg::ST_RAMP) || (state_nxt == hsfs_pkg::ST_ON); // RL17
      ss_hold <= (state_nxt != hsfs_pkg::ST_RAMP) && (state_nxt != hsfs_pkg::ST_ON); // RL16
      out_discharge <= valid_r & discharge_nxt; // RL4
      pin_pulldown <= ~valid_nxt; // RL5
      current_limit_reference <= clamp_nxt; // RL15
      power_good_out <= (state_nxt == hsfs_pkg::ST_ON); // RL12 RL13 RL19
      overcurrent_warning_out <= ~cmp.cur_above_warn; // RL14
      overcurrent_warning_oe_n <= ~cmp.cur_above_warn; // RL14
    end
  end

  // ahb-lite slave: zero wait states, always okay
  assign acc = hsel & htrans[1] & hready;
  assign wr_pend_nxt = acc & hwrite;
  assign wr_addr_nxt = acc ? haddr[3:0] : wr_addr_r;
  assign status_w = '{zero: '0, clamp: current_limit_reference, discharge: discharge_r,
                      gf_fault: gf_fault_r, ss_fault: ss_fault_r, gate_low: gate_low_r,
                      dg_short: dg_short_r, ds_short: ds_short_r, en_on: en_on_r,
                      valid: valid_r, state: state_r};
  assign rd_mux = (haddr[3:0] == hsfs_pkg::REG_CTRL) ? ctrl_r
                : (haddr[3:0] == hsfs_pkg::REG_STATUS) ? status_w
                : (haddr[3:0] == hsfs_pkg::REG_IRQ_STAT) ? {27'h0, irq_stat_r}
                : (haddr[3:0] == hsfs_pkg::REG_IRQ_MASK) ? {27'h0, irq_mask_r}
                : 32'h0000_0000;
  assign ctrl_nxt = (wr_pend_r && wr_addr_r == hsfs_pkg::REG_CTRL) ?
                    (hwdata & hsfs_pkg::CTRL_RESET) : ctrl_r;
  assign irq_mask_nxt = (wr_pend_r && wr_addr_r == hsfs_pkg::REG_IRQ_MASK) ?
                        hwdata[hsfs_pkg::IRQ_W-1:0] : irq_mask_r;
  assign w1c = (wr_pend_r && wr_addr_r == hsfs_pkg::REG_IRQ_STAT) ?
               hwdata[hsfs_pkg::IRQ_W-1:0] : '0;
  assign events[hsfs_pkg::IRQ_FAULT] = (state_nxt == hsfs_pkg::ST_FAULT) &&
                                       (state_r != hsfs_pkg::ST_FAULT);
  assign events[hsfs_pkg::IRQ_PGOOD] = (state_nxt == hsfs_pkg::ST_ON) && !power_good_out;
  assign events[hsfs_pkg::IRQ_DISCH] = discharge_nxt && !discharge_r && valid_r;
  assign events[hsfs_pkg::IRQ_POSTPONE] = (state_nxt == hsfs_pkg::ST_POSTPONE) &&
                                          (state_r != hsfs_pkg::ST_POSTPONE);
  assign events[hsfs_pkg::IRQ_OCWARN] = cmp.cur_above_warn && overcurrent_warning_oe_n;
  assign irq_stat_nxt = (irq_stat_r & ~w1c) | events;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      ctrl_r <= hsfs_pkg::CTRL_RESET;
      irq_mask_r <= hsfs_pkg::IRQ_MASK_RESET;
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= (acc && !hwrite) ? rd_mux : hrdata;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      ctrl_r <= ctrl_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_insert_wait: assert property ( // RL1
    (state_r == hsfs_pkg::ST_INSERT && ins_cnt_r < INS_CYC - 1) |=> !gate_enable)
    else $error("switch turned on before insertion delay ended");
  chk_disch_qualify: assert property ( // RL2
    $rose(pd_cmd_r) |-> $past(in_band) && $past(qual_cnt_r) == QUAL_CYC - 1)
    else $error("discharge command without full in-band qualification");
  chk_disch_delay: assert property ( // RL3
    $rose(discharge_r) |-> $past(pd_cmd_r) && $past(dly_cnt_r) == DLY_CYC - 1)
    else $error("discharge began without its start delay");
  chk_disch_path: assert property ( // RL4
    out_discharge |-> !gate_enable ##1 (out_discharge || !discharge_r))
    else $error("output pull-down active with switch on");
  chk_pin_pulldown: assert property ( // RL5
    (!valid_r && !cmp.uvlo_rise) |=> pin_pulldown && !gate_enable)
    else $error("pin pull-down released while input invalid");
  chk_en_hold: assert property ( // RL7
    (valid_r && cmp.uvlo_hold && en_on_r && cmp.pin_hold) |=> en_on_r)
    else $error("enable dropped while above the off level");
  chk_ds_postpone: assert property ( // RL8
    (state_r == hsfs_pkg::ST_POSTPONE && cmp.vout_above_80 && en_go && !discharge_r)
    |=> state_r == hsfs_pkg::ST_POSTPONE && ds_short_r)
    else $error("drain-source short did not postpone start-up");
  chk_ss_timeout: assert property ( // RL13
    (ss_to && !up_ok && en_go && !discharge_r)
    |=> state_r == hsfs_pkg::ST_FAULT && ss_fault_r ##1 !power_good_out)
    else $error("soft-start timeout did not latch a fault");
  chk_ocw_level: assert property ( // RL14
    cmp.cur_above_warn |=> !overcurrent_warning_oe_n && !overcurrent_warning_out)
    else $error("overcurrent warning not pulled low");
  chk_clamp_low: assert property ( // RL15
    !cmp.vout_above_abs |=> current_limit_reference == hsfs_pkg::CLAMP_LOW)
    else $error("lowest clamp not selected at low output");
  chk_fault_latch: assert property ( // RL19
    (state_r == hsfs_pkg::ST_FAULT && en_go && valid_r && !discharge_r && cmp.uvlo_hold)
    |=> state_r == hsfs_pkg::ST_FAULT && !power_good_out && !gate_enable)
    else $error("latched fault released without enable cycle");

  cov_power_good: cover property ($rose(power_good_out));
  cov_fault: cover property ($rose(state_r == hsfs_pkg::ST_FAULT));
  cov_postpone: cover property (state_r == hsfs_pkg::ST_POSTPONE ##1 state_r == hsfs_pkg::ST_RAMP);
  cov_discharge: cover property ($rose(out_discharge));

endmodule : hsfs_seq
`default_nettype wire

// ### hsfs_pkg.sv
// constants, comparator bundle and state types for the hot-swap fault sequencer
package hsfs_pkg;

  // timer clock and documented times
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned INSERT_DELAY_US = 1000;
  localparam int unsigned DISCH_QUAL_US = 80;
  localparam int unsigned DISCH_START_US = 2000;
  localparam int unsigned GATE_FAULT_US = 200000;
  localparam int unsigned SS_MAX_US = 200000;
  localparam int unsigned INSERT_DELAY_CYC = INSERT_DELAY_US * CLK_MHZ;
  localparam int unsigned DISCH_QUAL_CYC = DISCH_QUAL_US * CLK_MHZ;
  localparam int unsigned DISCH_START_CYC = DISCH_START_US * CLK_MHZ;
  localparam int unsigned GATE_FAULT_CYC = GATE_FAULT_US * CLK_MHZ;
  localparam int unsigned SS_MAX_CYC = SS_MAX_US * CLK_MHZ;
  localparam int unsigned CNT_W = 32;

  // register offsets (byte addresses, low nibble decoded)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hc;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // interrupt status / mask bits
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_PGOOD = 1;
  localparam int unsigned IRQ_DISCH = 2;
  localparam int unsigned IRQ_POSTPONE = 3;
  localparam int unsigned IRQ_OCWARN = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // synchronised comparator flags, all active high
  typedef struct packed {
    logic uvlo_rise;        // input above lockout rising threshold
    logic uvlo_hold;        // input above rising threshold minus hysteresis
    logic pin_on;           // enable_discharge_pin above on level
    logic pin_hold;         // enable_discharge_pin above on level minus hysteresis
    logic pin_above_lo;     // pin above lower discharge threshold
    logic pin_above_hi;     // pin above upper discharge threshold
    logic vout_above_80;    // drain_source_short_level
    logic vout_above_70;    // drain_source_release_level
    logic vout_above_90;    // output close to input
    logic vout_above_40;
    logic vout_above_abs;   // output above the absolute clamp region level
    logic gate_below_short; // gate_drain_short_level
    logic gate_below_ok;    // gate_drain_ok_level
    logic gate_drive_low;   // gate drive below gate_low_level
    logic gate_near_pump;   // gate drive within margin of charge pump
    logic cur_above_warn;   // overcurrent_warning_level
  } hsfs_cmp_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_INSERT, ST_POSTPONE, ST_RAMP, ST_ON, ST_FAULT
  } hsfs_state_t;

  typedef enum logic [1:0] {
    CLAMP_LOW, CLAMP_START, CLAMP_MID, CLAMP_FULL
  } hsfs_clamp_t;

  // status register layout
  typedef struct packed {
    logic [18:0] zero;
    hsfs_clamp_t clamp;
    logic discharge;
    logic gf_fault;
    logic ss_fault;
    logic gate_low;
    logic dg_short;
    logic ds_short;
    logic en_on;
    logic valid;
    hsfs_state_t state;
  } hsfs_status_t;

endpackage : hsfs_pkg

// ### hsfs_ctl_model.sv
// front-end controller model driving the enable/discharge pin
`timescale 1ns/1ps
`default_nettype none
module hsfs_ctl_model (
  // command: 0 driven low, 1 discharge band, 2 driven high, 3 rc network
  input wire logic [1:0] mode,
  // pull-down on the pin from the device
  input wire logic pin_pulldown,
  // pin comparator flags: on, hold, above_lo, above_hi
  output logic [3:0] pin_flags
);
  always_comb begin
    case (mode)
      2'd1: pin_flags = 4'h2;
      2'd2: pin_flags = 4'hf;
      2'd3: pin_flags = pin_pulldown ? 4'h0 : 4'hf;
      default: pin_flags = 4'h0;
    endcase
  end
endmodule : hsfs_ctl_model
`default_nettype wire

// ### hsfs_seq_tb_top.sv
// self-checking bench for the hot-swap fault sequencer
`timescale 1ns/1ps
`default_nettype none
module hsfs_seq_tb_top;
  localparam int INS = 20;
  localparam int QUAL = 8;
  localparam int DLY = 16;
  localparam int SSC = 200;
  localparam int GE = 0, PG = 1, SH = 2, OD = 3, PP = 4, OW = 5, OE = 6, IQ = 7;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, gate_enable, ss_hold, out_discharge, pin_pulldown, irq;
  logic power_good_out, overcurrent_warning_out, overcurrent_warning_oe_n;
  logic [31:0] hrdata;
  hsfs_pkg::hsfs_cmp_t cmp_r = '0;
  hsfs_pkg::hsfs_cmp_t cmp_w;
  hsfs_pkg::hsfs_clamp_t clamp;
  logic [1:0] pin_mode = 2'd0;
  logic [3:0] pin_flags;
  logic [7:0] mon;
  logic rd_pend = 1'b0;
  logic irq_a;
  logic [63:0] rq[$];
  int n_errors = 0;
  int tests_run = 0;
  int n, t0;

  always #5 hclk = ~hclk;

  hsfs_ctl_model i_ctl (.mode(pin_mode), .pin_pulldown(pin_pulldown), .pin_flags(pin_flags));

  hsfs_seq #(.INS_CYC(INS), .QUAL_CYC(QUAL), .DLY_CYC(DLY), .GF_CYC(SSC), .SS_CYC(SSC)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmp_async(cmp_w),
    .gate_enable(gate_enable), .ss_hold(ss_hold), .out_discharge(out_discharge),
    .pin_pulldown(pin_pulldown), .current_limit_reference(clamp),
    .power_good_out(power_good_out), .overcurrent_warning_out(overcurrent_warning_out),
    .overcurrent_warning_oe_n(overcurrent_warning_oe_n), .irq(irq)
  );

  always_comb begin
    cmp_w = cmp_r;
    {cmp_w.pin_on, cmp_w.pin_hold, cmp_w.pin_above_lo, cmp_w.pin_above_hi} = pin_flags;
  end
  assign mon = {irq, overcurrent_warning_oe_n, overcurrent_warning_out, pin_pulldown,
                out_discharge, ss_hold, power_good_out, gate_enable};

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // waits from the launching edge until mon[idx] shows val; n holds the cycles taken
  task automatic wait_sig(input int idx, input logic val, input int lim);
    #1;
    n = 0;
    while (mon[idx] !== val && n < lim) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (mon[idx] !== val) begin
      check(32'(mon[idx]), 32'(val));
      complete_run();
    end
  endtask : wait_sig

  task automatic hold_chk(input logic [7:0] m, input logic [7:0] v, input int c);
    logic bad;
    bad = 1'b0;
    repeat (c) begin
      @(posedge hclk);
      #1;
      if ((mon & m) !== v) bad = 1'b1;
    end
    check(32'(bad), 32'h0);
  endtask : hold_chk

  // single ahb-lite transfer; a read notes mask and expected value for the monitor
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [31:0] m, input logic [31:0] e);
    int k;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {28'h0, a};
    hwrite <= wr;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    if (!wr) rq.push_back({m, e});
    rd_pend <= !wr;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    rd_pend <= 1'b0;
    if (k >= 40) begin
      check(32'h0, 32'h1);
      complete_run();
    end
  endtask : bus

  always @(posedge hclk) begin : rd_monitor
    logic [63:0] t;
    if (rd_pend && hreadyout) begin
      t = rq.pop_front();
      check(hrdata & t[63:32], t[31:0]);
    end
  end

  initial begin
    void'($urandom(32'h6cca));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check(32'(mon), 32'h74);
    bus(1'b0, hsfs_pkg::REG_CTRL, 32'h0, 32'hffffffff, hsfs_pkg::CTRL_RESET);
    bus(1'b0, hsfs_pkg::REG_IRQ_MASK, 32'h0, 32'hffffffff, 32'h0);
    @(posedge hclk);
    cmp_r.uvlo_rise <= 1'b1;
    cmp_r.uvlo_hold <= 1'b1;
    pin_mode <= 2'd3;
    wait_sig(PP, 1'b0, 8);
    @(posedge hclk);
    cmp_r.uvlo_rise <= 1'b0;
    hold_chk(8'h15, 8'h04, INS);
    wait_sig(GE, 1'b1, 8);
    check(32'(mon[SH]), 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      cmp_r.vout_above_abs <= (i > 0);
      cmp_r.vout_above_40 <= (i > 1);
      cmp_r.vout_above_80 <= (i > 2);
      cmp_r.vout_above_70 <= (i > 2);
      repeat (5) @(posedge hclk);
      #1;
      check(32'(clamp), 32'(i));
    end
    @(posedge hclk);
    cmp_r.vout_above_90 <= 1'b1;
    cmp_r.gate_near_pump <= 1'b1;
    wait_sig(PG, 1'b1, 8);
    bus(1'b0, hsfs_pkg::REG_STATUS, 32'h0, 32'h7, 32'h4);
    $display("test start-up done");
    @(posedge hclk);
    cmp_r.cur_above_warn <= 1'b1;
    wait_sig(OW, 1'b0, 8);
    check(32'(mon[OE]), 32'h0);
    repeat ($urandom_range(12, 2)) @(posedge hclk);
    cmp_r.cur_above_warn <= 1'b0;
    wait_sig(OW, 1'b1, 8);
    check(32'(mon[OE]), 32'h1);
    bus(1'b0, hsfs_pkg::REG_IRQ_STAT, 32'h0, 32'h10, 32'h10);
    bus(1'b1, hsfs_pkg::REG_IRQ_MASK, 32'h1f, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    #1;
    irq_a = irq;
    bus(1'b1, hsfs_pkg::REG_IRQ_MASK, 32'h0, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    #1;
    check(32'(irq_a ^ irq), 32'h1);
    bus(1'b1, hsfs_pkg::REG_IRQ_STAT, 32'h1f, 32'h0, 32'h0);
    bus(1'b0, hsfs_pkg::REG_IRQ_STAT, 32'h0, 32'h1f, 32'h0);
    repeat (3) @(posedge hclk);
    #1;
    check(32'(mon[IQ]), 32'h0);
    $display("test warning and interrupt done");
    @(posedge hclk);
    cmp_r.gate_drive_low <= 1'b1;
    wait_sig(PG, 1'b0, 8);
    check(32'(mon[GE]), 32'h0);
    bus(1'b0, hsfs_pkg::REG_STATUS, 32'h0, 32'h87, 32'h85);
    @(posedge hclk);
    cmp_r <= '{uvlo_hold: 1'b1, gate_drive_low: 1'b1, default: 1'b0};
    hold_chk(8'h03, 8'h00, 20);
    @(posedge hclk);
    pin_mode <= 2'd0;
    repeat (10) @(posedge hclk);
    pin_mode <= 2'd2;
    wait_sig(GE, 1'b1, INS + 8);
    t0 = n;
    wait_sig(GE, 1'b0, SSC + 20);
    check(32'(t0 + n >= SSC && t0 + n <= SSC + 8), 32'h1);
    bus(1'b0, hsfs_pkg::REG_STATUS, 32'h0, 32'h307, 32'h305);
    $display("test latched faults done");
    @(posedge hclk);
    pin_mode <= 2'd0;
    cmp_r.gate_drive_low <= 1'b0;
    cmp_r.gate_below_short <= 1'b1;
    repeat (10) @(posedge hclk);
    pin_mode <= 2'd2;
    hold_chk(8'h05, 8'h04, INS + 10);
    bus(1'b0, hsfs_pkg::REG_STATUS, 32'h0, 32'h7, 32'h2);
    @(posedge hclk);
    cmp_r.vout_above_80 <= 1'b1;
    cmp_r.vout_above_70 <= 1'b1;
    cmp_r.gate_below_ok <= 1'b1;
    hold_chk(8'h01, 8'h00, INS + 10);
    bus(1'b0, hsfs_pkg::REG_STATUS, 32'h0, 32'h27, 32'h22);
    @(posedge hclk);
    cmp_r.vout_above_80 <= 1'b0;
    hold_chk(8'h01, 8'h00, 20);
    @(posedge hclk);
    cmp_r.vout_above_70 <= 1'b0;
    wait_sig(GE, 1'b1, INS + 10);
    $display("test postponed start done");
    @(posedge hclk);
    pin_mode <= 2'd1;
    repeat ($urandom_range(QUAL - 3, 1)) @(posedge hclk);
    pin_mode <= 2'd2;
    hold_chk(8'h08, 8'h00, QUAL + DLY + 8);
    @(posedge hclk);
    pin_mode <= 2'd1;
    wait_sig(OD, 1'b1, QUAL + DLY + 10);
    check(32'(n >= QUAL + DLY), 32'h1);
    check(32'(mon[GE]), 32'h0);
    @(posedge hclk);
    pin_mode <= 2'd2;
    wait_sig(OD, 1'b0, 8);
    $display("test discharge done");
    wait_sig(GE, 1'b1, INS + 8);
    bus(1'b1, hsfs_pkg::REG_CTRL, 32'h0, 32'h0, 32'h0);
    wait_sig(GE, 1'b0, 8);
    bus(1'b0, hsfs_pkg::REG_CTRL, 32'h0, 32'hffffffff, 32'h0);
    bus(1'b1, hsfs_pkg::REG_CTRL, 32'h1, 32'h0, 32'h0);
    wait_sig(GE, 1'b1, INS + 8);
    $display("test run control done");
    @(posedge hclk);
    cmp_r.uvlo_hold <= 1'b0;
    wait_sig(PP, 1'b1, 8);
    @(posedge hclk);
    #1;
    check(32'(mon[GE]), 32'h0);
    $display("test input loss done");
    complete_run();
  end
endmodule : hsfs_seq_tb_top
`default_nettype wire
